//--- hw/imp_pkg.sv
// imp_pkg: constants and types for the indexed move / literal push execution block.
// assumes one core clock in which each instruction cycle is four phases of one clock each.
package imp_pkg;

	// data memory geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned OFS_W  = 7;

	// instruction encodings, matched under a mask
	localparam logic [15:0] MOVE_MASK = 16'hFF80;
	localparam logic [15:0] MOVE_OP   = 16'hEB80;
	localparam logic [15:0] PUSH_MASK = 16'hFF00;
	localparam logic [15:0] PUSH_OP   = 16'hFA00;

	// window of indirect-addressing registers in the data space
	localparam logic [ADDR_W-1:0] IND_LO = 12'h0FF8;
	localparam logic [ADDR_W-1:0] IND_HI = 12'h0FFF;

	// values after reset
	localparam logic [ADDR_W-1:0] FP_RST   = 12'h0000;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// phases per instruction cycle
	localparam int unsigned NUM_PHASES = 4;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_MV1,
		ST_MV2,
		ST_PUSH
	} imp_state_t;

	// one data memory request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              rd;
		logic              wr;
	} imp_dm_req_t;

endpackage

//--- hw/imp_qphase.sv
// imp_qphase: four-phase sequencer, one phase per clock, as one-hot enables.
// assumes the core starts in the first phase when reset is released.
`timescale 1ns/1ps

module imp_qphase (
	input  wire logic       clk_sys_i, // core clock
	input  wire logic       reset_n_i, // async reset, active low
	output logic      [3:0] phase_o    // one-hot phase, bit 0 is the first phase
);

	logic [3:0] phase_q;

	// rotate the one-hot phase every clock
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_q <= 4'h1;
		end else begin
			phase_q <= {phase_q[2:0], phase_q[3]};
		end
	end

	assign phase_o = phase_q;

endmodule

//--- hw/imp_core.sv
// imp_core: execution of the indexed move and the literal push, with the frame pointer.
// assumes fetch presents each instruction word in the first phase of its cycle, and the
// second move word in the very next cycle; memory read data is valid in the same clock.
`timescale 1ns/1ps

// Functional notes
// - indexed move copies the source byte to the destination byte
// - each address is frame_pointer_two plus its own 7-bit unsigned offset
// - computed addresses may reach anywhere in the 4096-byte data space
// - a source in the indirect registers reads as zero
// - a destination in the indirect registers makes the move a no-operation
// - literal push stores the literal at frame_pointer_two, then decrements it
module imp_core (
	input  wire logic                             clk_sys_i,     // core clock
	input  wire logic                             reset_n_i,     // async reset, active low
	input  wire logic [15:0]                      instr_i,       // instruction word
	input  wire logic                             instr_valid_i, // word present in phase 1
	input  wire logic                             fp_wr_i,       // load frame pointer
	input  wire logic [imp_pkg::ADDR_W-1:0]       fp_wdata_i,    // frame pointer load value
	input  wire logic [imp_pkg::DATA_W-1:0]       mem_rdata_i,   // data memory read data
	output imp_pkg::imp_dm_req_t                  mem_req_o,     // data memory request
	output logic      [imp_pkg::ADDR_W-1:0]       fp_o,          // frame_pointer_two
	output logic                                  busy_o,        // executing an instruction
	output logic                                  done_o,        // last phase of instruction
	output logic                                  flags_we_o     // status flag write enable
);

	logic [3:0]                     phase;
	imp_pkg::imp_state_t            st_q;
	logic [imp_pkg::OFS_W-1:0]      zs_q;
	logic [imp_pkg::OFS_W-1:0]      zd_q;
	logic [imp_pkg::DATA_W-1:0]     lit_q;
	logic [imp_pkg::DATA_W-1:0]     src_q;
	logic [imp_pkg::ADDR_W-1:0]     fp_q;
	imp_pkg::imp_dm_req_t           req_q;

	wire logic                      q1;
	wire logic                      q3;
	wire logic                      q4;
	wire logic                      idle_w;
	wire logic                      is_move_w;
	wire logic                      is_push_w;
	wire logic                      accept_w;
	wire logic [imp_pkg::OFS_W-1:0] ofs_w;
	wire logic [imp_pkg::ADDR_W-1:0] addr_w;
	wire logic                      addr_ind_w;
	wire logic                      rd_ind_w;

	imp_qphase u_qphase (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.phase_o   (phase)
	);

	// phase enables and decode
	assign q1        = phase[0];
	assign q3        = phase[2];
	assign q4        = phase[3];
	assign idle_w    = (st_q == imp_pkg::ST_IDLE);
	assign is_move_w = ((instr_i & imp_pkg::MOVE_MASK) == imp_pkg::MOVE_OP);
	assign is_push_w = ((instr_i & imp_pkg::PUSH_MASK) == imp_pkg::PUSH_OP);
	assign accept_w  = q1 && idle_w && instr_valid_i && (is_move_w || is_push_w);

	function automatic logic [imp_pkg::ADDR_W-1:0] ADDR_SUM(
		input logic [imp_pkg::ADDR_W-1:0] base,
		input logic [imp_pkg::OFS_W-1:0]  ofs
	);
		// full-width sum, no clamp, so any byte of the space is reachable
		ADDR_SUM = base + {{(imp_pkg::ADDR_W-imp_pkg::OFS_W){1'b0}}, ofs};
	endfunction

	// address formation: offset zero-extended, sum wraps inside the 12-bit space
	assign ofs_w  = (st_q == imp_pkg::ST_MV1) ? zs_q :
	                (st_q == imp_pkg::ST_MV2) ? zd_q : '0;
	assign addr_w = ADDR_SUM(fp_q, ofs_w);

	// indirect register window check on the address being formed and on the address already issued
	assign addr_ind_w = (addr_w >= imp_pkg::IND_LO) && (addr_w <= imp_pkg::IND_HI);
	assign rd_ind_w   = (req_q.addr >= imp_pkg::IND_LO) && (req_q.addr <= imp_pkg::IND_HI);

	// sequencer: take words in phase 1, step the state in phase 4
	// word two is taken without a valid, so fetch must never stall between the two words
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q  <= imp_pkg::ST_IDLE;
			zs_q  <= '0;
			zd_q  <= '0;
			lit_q <= imp_pkg::ZERO_BYTE;
		end else if (q1) begin
			if (accept_w && is_move_w) begin
				zs_q <= instr_i[imp_pkg::OFS_W-1:0];
				st_q <= imp_pkg::ST_MV1;
			end else if (accept_w) begin
				lit_q <= instr_i[imp_pkg::DATA_W-1:0];
				st_q  <= imp_pkg::ST_PUSH;
			end else if (st_q == imp_pkg::ST_MV2) begin
				// second word is always fetched in the next cycle
				zd_q <= instr_i[imp_pkg::OFS_W-1:0];
			end
		end else if (q4) begin
			unique case (st_q)
				imp_pkg::ST_MV1:  st_q <= imp_pkg::ST_MV2;
				imp_pkg::ST_MV2:  st_q <= imp_pkg::ST_IDLE;
				imp_pkg::ST_PUSH: st_q <= imp_pkg::ST_IDLE;
				imp_pkg::ST_IDLE: st_q <= imp_pkg::ST_IDLE;
			endcase
		end
	end

	// memory strobes: address set in phase 3, strobe stands through phase 4
	// memory must answer in that same clock; no wait state can be inserted
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_q <= '0;
		end else if (q3) begin
			req_q.addr  <= addr_w;
			req_q.rd    <= (st_q == imp_pkg::ST_MV1);
			req_q.wr    <= (st_q == imp_pkg::ST_PUSH) ||
			               ((st_q == imp_pkg::ST_MV2) && !addr_ind_w);
			req_q.wdata <= (st_q == imp_pkg::ST_PUSH) ? lit_q : src_q;
		end else if (q4) begin
			req_q.rd <= 1'b0;
			req_q.wr <= 1'b0;
		end
	end

	// source byte capture; an indirect register never returns live data
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			src_q <= imp_pkg::ZERO_BYTE;
		end else if (q4 && req_q.rd) begin
			src_q <= rd_ind_w ? imp_pkg::ZERO_BYTE : mem_rdata_i;
		end
	end

	// frame pointer: push decrement wins over a load in the same clock
	// a load during a move shifts its addresses, so fetch keeps loads to idle cycles
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fp_q <= imp_pkg::FP_RST;
		end else if (q4 && (st_q == imp_pkg::ST_PUSH)) begin
			fp_q <= fp_q - 12'h001;
		end else if (fp_wr_i) begin
			fp_q <= fp_wdata_i;
		end
	end

	assign mem_req_o  = req_q;
	assign fp_o       = fp_q;
	assign busy_o     = !idle_w;
	assign done_o     = q4 && ((st_q == imp_pkg::ST_MV2) || (st_q == imp_pkg::ST_PUSH));
	assign flags_we_o = 1'b0;

	// checks: each watches what this block drives, not its surroundings;
	// excluded destinations are a software duty and have no check here
	a_src_address: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(req_q.rd) |-> (req_q.addr == ADDR_SUM(fp_q, zs_q)))
		else $error("move source address is not pointer plus source offset");

	a_dst_address: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(req_q.wr && (st_q == imp_pkg::ST_MV2)) |-> (req_q.addr == ADDR_SUM(fp_q, zd_q)))
		else $error("move destination address is not pointer plus destination offset");

	a_move_copy: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(q4 && req_q.rd && !rd_ind_w) ##4 (req_q.wr && (st_q == imp_pkg::ST_MV2))
		|-> (req_q.wdata == $past(mem_rdata_i, 4)))
		else $error("move wrote a value other than the source byte");

	a_src_indirect: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(q4 && req_q.rd && rd_ind_w) |=> (src_q == imp_pkg::ZERO_BYTE))
		else $error("indirect source did not read as zero");

	a_dst_nop: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(q4 && (st_q == imp_pkg::ST_MV2) && rd_ind_w) |-> !req_q.wr)
		else $error("move wrote to an indirect destination");

	a_push_store: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(accept_w && is_push_w && !fp_wr_i) |-> ##3 (req_q.wr
		&& req_q.wdata == $past(instr_i[7:0], 3) && req_q.addr == $past(fp_q, 3))
		##1 (fp_q == $past(fp_q, 1) - 12'h001))
		else $error("push did not store the literal then decrement the pointer");

	a_move_length: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(accept_w && is_move_w) |-> ##3 (req_q.rd && !done_o) ##4 (done_o && busy_o) ##1 !busy_o)
		else $error("move did not take exactly two instruction cycles");

	a_push_length: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(accept_w && is_push_w) |-> (!done_o [*3] ##1 done_o ##1 !busy_o && !flags_we_o))
		else $error("push did not take exactly one instruction cycle");

	a_read_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		req_q.rd |=> !req_q.rd)
		else $error("read strobe stood longer than one clock");

	a_write_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		req_q.wr |=> !req_q.wr)
		else $error("write strobe stood longer than one clock");

	a_push_no_read: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(st_q == imp_pkg::ST_PUSH) |-> !req_q.rd)
		else $error("push issued a memory read");

	a_move_early_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(st_q == imp_pkg::ST_MV1) |-> !req_q.wr)
		else $error("move wrote during its first cycle");

	a_dst_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(q4 && (st_q == imp_pkg::ST_MV2) && !rd_ind_w) |-> req_q.wr)
		else $error("move skipped the write to an ordinary destination");

	a_second_word: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(q1 && (st_q == imp_pkg::ST_MV2)) |=> (zd_q == $past(instr_i[imp_pkg::OFS_W-1:0])))
		else $error("destination offset not taken from the second move word");

	a_move_keeps_fp: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(busy_o && (st_q != imp_pkg::ST_PUSH) && !fp_wr_i) |=> (fp_q == $past(fp_q)))
		else $error("move changed the frame pointer");

	a_busy_accept: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		accept_w |=> busy_o)
		else $error("accepted instruction did not raise busy");

endmodule

//--- verif/tb.sv
// tb: self-checking bench for imp_core, indexed move and literal push.
// assumes the phase sequencer is in phase 1 at the first edge after reset.
`timescale 1ns/1ps
module tb;
	logic                 clk_sys_i = 0;
	logic                 reset_n_i = 0;
	logic [15:0]          instr_i = 16'h0000;
	logic                 instr_valid_i = 0;
	logic                 fp_wr_i = 0;
	logic [11:0]          fp_wdata_i = 12'h000;
	logic [7:0]           mem_rdata_i = 8'h00;
	imp_pkg::imp_dm_req_t mem_req_o;
	logic [11:0]          fp_o;
	logic                 busy_o;
	logic                 done_o;
	logic                 flags_we_o;
	logic [7:0]           mem [0:4095];
	int                   err_count = 0;
	int                   comparisons = 0;

	// 125 MHz core clock
	always #4 clk_sys_i = ~clk_sys_i;

	imp_core dut (
		.clk_sys_i     (clk_sys_i),
		.reset_n_i     (reset_n_i),
		.instr_i       (instr_i),
		.instr_valid_i (instr_valid_i),
		.fp_wr_i       (fp_wr_i),
		.fp_wdata_i    (fp_wdata_i),
		.mem_rdata_i   (mem_rdata_i),
		.mem_req_o     (mem_req_o),
		.fp_o          (fp_o),
		.busy_o        (busy_o),
		.done_o        (done_o),
		.flags_we_o    (flags_we_o)
	);

	// bench memory; idle reads show inverted data so a stale byte cannot pass
	always @(posedge clk_sys_i) if (mem_req_o.wr) mem[mem_req_o.addr] <= mem_req_o.wdata;
	always @(negedge clk_sys_i) mem_rdata_i <= mem_req_o.rd ? mem[mem_req_o.addr]
		: ~mem[mem_req_o.addr];

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// load the pointer in idle; four clocks keep the phase alignment
	task automatic set_fp(input logic [11:0] v);
		fp_wr_i = 1;
		fp_wdata_i = v;
		@(negedge clk_sys_i);
		fp_wr_i = 0;
		repeat (3) @(negedge clk_sys_i);
		check("fp load", fp_o, v);
	endtask

	// called just before phase 1, returns just before the next phase 1
	task automatic push(input logic [7:0] k, input logic [11:0] a);
		instr_i = 16'hFA00 | {8'h00, k};
		instr_valid_i = 1;
		@(negedge clk_sys_i);
		instr_valid_i = 0;
		check("busy", busy_o, 1'h1);
		// strobe and done stand only in phase 4
		repeat (2) @(negedge clk_sys_i);
		check("push wr", mem_req_o.wr, 1'h1);
		check("push addr", mem_req_o.addr, a);
		check("push data", mem_req_o.wdata, k);
		check("push done", done_o, 1'h1);
		@(negedge clk_sys_i);
		check("push dec", fp_o, 12'(a - 12'h001));
		check("push wr end", mem_req_o.wr, 1'h0);
	endtask

	task automatic move(input logic [6:0] zs, input logic [6:0] zd, input logic [11:0] fp,
		input logic [7:0] sv, input logic wr, input logic [7:0] d);
		logic [11:0] s;
		logic [11:0] t;
		s = fp + {5'h00, zs};
		t = fp + {5'h00, zd};
		set_fp(fp);
		mem[s] = sv;
		instr_i = 16'hEB80 | {9'h000, zs};
		instr_valid_i = 1;
		@(negedge clk_sys_i);
		instr_valid_i = 0;
		instr_i = 16'hF000 | {9'h000, zd}; // upper bits of word two are don't-care
		repeat (2) @(negedge clk_sys_i);
		check("move rd", mem_req_o.rd, 1'h1);
		check("src addr", mem_req_o.addr, s);
		check("early done", done_o, 1'h0);
		repeat (4) @(negedge clk_sys_i);
		check("move wr", mem_req_o.wr, wr);
		if (wr) begin
			check("dst addr", mem_req_o.addr, t);
			check("move data", mem_req_o.wdata, d);
		end
		check("move done", done_o, 1'h1);
		check("move fp", fp_o, fp);
		check("flags", flags_we_o, 1'h0);
		@(negedge clk_sys_i);
		check("move idle", busy_o, 1'h0);
	endtask

	// back to back pushes, pointer wraps below zero
	task automatic t_push();
		set_fp(12'h001);
		push(8'h5A, 12'h001);
		push(8'hFF, 12'h000);
		push(8'h00, 12'hFFF);
		@(negedge clk_sys_i);
		check("push fp", fp_o, 12'hFFE);
		check("idle", busy_o, 1'h0);
		repeat (3) @(negedge clk_sys_i);
		$display("test push done");
	endtask

	task automatic t_moves();
		// destinations stay clear of the program counter and stack top registers
		move(7'h05, 7'h06, 12'h080, 8'h33, 1'h1, 8'h33);
		move(7'h7F, 7'h00, 12'hF00, 8'hC3, 1'h1, 8'hC3);
		move(7'h7F, 7'h10, 12'hFF0, 8'h96, 1'h1, 8'h96);
		$display("test move done");
	endtask

	task automatic t_indirect();
		move(7'h08, 7'h20, 12'hFF0, 8'h77, 1'h1, 8'h00);
		move(7'h00, 7'h0F, 12'hFF0, 8'h44, 1'h0, 8'h00);
		$display("test indirect done");
	endtask

	initial begin
		repeat (6) @(negedge clk_sys_i);
		check("rst out", {mem_req_o.rd, mem_req_o.wr, busy_o, done_o}, 4'h0);
		check("rst fp", fp_o, 12'h000);
		reset_n_i = 1;
		t_push();
		t_moves();
		t_indirect();
		end_sim();
	end

	// watchdog, far beyond the 86 clocks the tests need
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		err_count++;
		end_sim();
	end
endmodule
